// [pkg/dcwsm_pkg.sv]
/*
  shared types and constants of the drive control word state machine.
  assumes one clock domain; the fieldbus command word arrives already on that clock.
*/
package dcwsm_pkg;

  // ------------------------------------------------------------
  // command word field positions
  // ------------------------------------------------------------
  localparam int CW_SWITCH_ON = 0;
  localparam int CW_ENABLE_VOLTAGE = 1;
  localparam int CW_QUICK_STOP_N = 2;
  localparam int CW_ENABLE_OPERATION = 3;
  localparam int CW_FAULT_RESET = 7;
  localparam int CW_HALT = 8;
  localparam int CW_ASSIGN_LSB = 11;
  localparam logic [15:0] CMD_WORD_RESET = 16'h0000;
  localparam logic [15:0] CMD_RESERVED_MASK = 16'h0670;

  // ------------------------------------------------------------
  // status word values, low seven bits, voltage bit kept apart
  // ------------------------------------------------------------
  localparam logic [15:0] STATUS_MASK = 16'h006F;
  localparam logic [15:0] SW_NOT_READY = 16'h0000;
  localparam logic [15:0] SW_SWITCH_ON_DISABLED = 16'h0040;
  localparam logic [15:0] SW_READY = 16'h0021;
  localparam logic [15:0] SW_SWITCHED_ON = 16'h0023;
  localparam logic [15:0] SW_OPERATION_ENABLED = 16'h0027;
  localparam logic [15:0] SW_QUICK_STOP = 16'h0007;
  localparam logic [15:0] SW_FAULT_REACTION = 16'h002F;
  localparam logic [15:0] SW_FAULT = 16'h0028;
  localparam logic [15:0] SW_FAULT_AFTER_QS = 16'h0008;
  localparam int SW_VOLTAGE_ENABLED = 4;
  localparam int SW_DIRECTION = 15;

  // ------------------------------------------------------------
  // function source codes for the assignable bits 11..15
  // ------------------------------------------------------------
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_BIT11 = 3'h1;
  localparam logic [2:0] SRC_BIT15 = 3'h5;
  localparam logic [2:0] SRC_DIR_DEFAULT = SRC_BIT11;

  typedef enum logic [1:0] {
    STOP_RAMP,
    STOP_FAST,
    STOP_FREEWHEEL,
    STOP_DC_INJECTION
  } dcwsm_stop_t;

  typedef enum logic [2:0] {
    ST_NOT_READY,
    ST_SWITCH_ON_DISABLED,
    ST_READY,
    ST_SWITCHED_ON,
    ST_OPERATION_ENABLED,
    ST_QUICK_STOP,
    ST_FAULT_REACTION,
    ST_FAULT
  } dcwsm_state_t;

  typedef struct packed {
    logic [2:0] fieldbus_dir_source;
    logic [2:0] fieldbus_fast_stop_source;
    logic [2:0] fieldbus_freewheel_source;
    logic [2:0] fieldbus_dc_inject_source;
    dcwsm_stop_t stop_type;
    logic disable_stop_on_ramp;
    logic fault_motor_power;
    logic fault_supply_need;
  } dcwsm_cfg_t;

  typedef struct packed {
    logic valid;
    logic is_config;
  } dcwsm_param_req_t;

  typedef struct packed {
    logic accept;
    logic reject;
  } dcwsm_param_ans_t;

  typedef struct packed {
    logic motor_power;
    logic supply_need;
    logic contactor;
    logic halt;
    dcwsm_stop_t halt_stop_type;
    logic reverse;
    logic dc_inject;
  } dcwsm_drive_t;

endpackage

// [core/dcwsm_sync.sv]
/*
  two flip-flop synchroniser for a group of pin levels.
  assumes the inputs are asynchronous levels; only the second stage is read outside.
*/
`timescale 1ns/1ns
module dcwsm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // dcwsm_sync

// [core/dcwsm_top.sv]
/*
  drive control word state machine: decodes the fieldbus command word into drive states,
  reports the status word, gates configuration writes and motor power by state.
  assumes the command word, its write strobe and the fault inputs come from logic on SYS_CLK_I;
  the terminal stop pins and the mains-present pin are asynchronous.
*/
// Behaviour
// RULE_01 - bits 0-3 and 7 hold switch on, voltage, quick stop (low), run and fault reset; 4-6, 9, 10 are reserved.
// RULE_02 - shutdown, switch on, enable and disable operation, disable voltage and quick stop decode from low bits.
// RULE_03 - fault reset acts only on a rise of bit 7 and leaves fault for switch on disabled once the cause is gone.
// RULE_04 - halt in bit 8 stops motion by the configured stop type while staying in operation enabled.
// RULE_05 - while halt is active the motor gets no power and no torque.
// RULE_06 - a fast stop from a terminal or an assigned command bit moves the drive to switched on.
// RULE_07 - a freewheel stop from a terminal or an assigned command bit moves the drive to switch on disabled.
// RULE_08 - bits 11 to 15 are assignable, each picked by a source code to feed a drive function such as dc injection.
// RULE_09 - by default bit 11 is the direction request, 0 forward and 1 reverse.
// RULE_10 - config writes pass in states 1, 2, 3 and 8, fail in 5 and 6, and in state 4 force switch on disabled.
// RULE_11 - motor power flows only in operation enabled and during the fast stop of quick stop active; code also allows it in fault reaction.
// RULE_12 - in fault reaction active, supply need and motor power follow the configured error response.
// RULE_13 - non configuration parameters are accepted in every state with no transition.
// RULE_14 - the status word masked with 006F reads the documented code of each state.
// RULE_15 - disable operation freewheels straight to switched on at setting 0, or ramps down first at setting 1.
// RULE_16 - after reset the drive leaves not ready alone for switch on disabled and takes commands only from there.
// RULE_17 - a command word that matches no transition of the current state leaves the state unchanged.
`timescale 1ns/1ns
module dcwsm_top
  import dcwsm_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CMD_WR_I,
  input wire logic [15:0] CMD_WORD_I,
  output logic [15:0] CMD_WORD_O,
  output logic [15:0] STATUS_WORD_O,
  output dcwsm_pkg::dcwsm_state_t STATE_O,
  input wire dcwsm_pkg::dcwsm_cfg_t CFG_I,
  input wire logic FAST_STOP_PIN_I,
  input wire logic FREEWHEEL_PIN_I,
  input wire logic MAINS_PRESENT_PIN_I,
  input wire logic FAULT_DETECT_I,
  input wire logic FAULT_CAUSE_ACTIVE_I,
  input wire logic FAULT_REACTION_DONE_I,
  input wire logic RAMP_STOPPED_I,
  input wire dcwsm_pkg::dcwsm_param_req_t PARAM_REQ_I,
  output dcwsm_pkg::dcwsm_param_ans_t PARAM_ANS_O,
  output dcwsm_pkg::dcwsm_drive_t DRIVE_O
);

  // ------------------------------------------------------------
  // state record
  // ------------------------------------------------------------
  typedef struct packed {
    dcwsm_state_t state;
    logic [15:0] cmd;
    logic fault_reset_prev;
    logic ramping;
    logic qs_stopped;
    logic fault_after_qs;
    dcwsm_param_ans_t ans;
    logic [15:0] status;
    dcwsm_drive_t drive;
  } dcwsm_regs_t;

  dcwsm_regs_t r_q;
  dcwsm_regs_t r_d;
  logic [2:0] pins_sync;
  logic fast_pin;
  logic free_pin;
  logic mains_ok;

  // pins are asynchronous, so they pass two stages before the decoder
  dcwsm_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk_i(SYS_CLK_I),
    .reset_n_i(RESET_N_I),
    .async_i({MAINS_PRESENT_PIN_I, FREEWHEEL_PIN_I, FAST_STOP_PIN_I}),
    .sync_o(pins_sync)
  );

  assign fast_pin = pins_sync[0];
  assign free_pin = pins_sync[1];
  assign mains_ok = pins_sync[2];

  // ------------------------------------------------------------
  // assignable bit selection
  // ------------------------------------------------------------
  function automatic logic pick_bit(input logic [2:0] src, input logic [15:0] word);
    logic [2:0] idx;
    idx = 3'(src - SRC_BIT11);
    if (src >= SRC_BIT11 && src <= SRC_BIT15) begin // RULE_08
      pick_bit = word[CW_ASSIGN_LSB + int'(idx)];
    end else begin
      pick_bit = 1'b0;
    end
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [15:0] c;
    logic cmd_shutdown;
    logic cmd_switch_on;
    logic cmd_enable_op;
    logic cmd_disable_voltage;
    logic cmd_quick_stop;
    logic fault_reset_edge;
    logic fast_req;
    logic free_req;
    logic cfg_write;
    logic stop_power;
    c = r_q.cmd;
    r_d = r_q;
    // reserved bits are written zero and never stored
    if (CMD_WR_I) begin
      r_d.cmd = CMD_WORD_I & ~CMD_RESERVED_MASK; // RULE_01
    end
    cmd_shutdown = c[CW_QUICK_STOP_N] && c[CW_ENABLE_VOLTAGE] && !c[CW_SWITCH_ON]; // RULE_02
    cmd_switch_on = c[CW_QUICK_STOP_N] && c[CW_ENABLE_VOLTAGE] && c[CW_SWITCH_ON] &&
                    !c[CW_ENABLE_OPERATION]; // RULE_02
    cmd_enable_op = c[CW_QUICK_STOP_N] && c[CW_ENABLE_VOLTAGE] && c[CW_SWITCH_ON] &&
                    c[CW_ENABLE_OPERATION]; // RULE_02
    cmd_disable_voltage = !c[CW_ENABLE_VOLTAGE]; // RULE_02
    cmd_quick_stop = c[CW_ENABLE_VOLTAGE] && !c[CW_QUICK_STOP_N]; // RULE_02
    fault_reset_edge = c[CW_FAULT_RESET] && !r_q.fault_reset_prev; // RULE_03
    r_d.fault_reset_prev = c[CW_FAULT_RESET];
    fast_req = fast_pin || pick_bit(CFG_I.fieldbus_fast_stop_source, c); // RULE_06
    free_req = free_pin || pick_bit(CFG_I.fieldbus_freewheel_source, c); // RULE_07
    cfg_write = PARAM_REQ_I.valid && PARAM_REQ_I.is_config;
    r_d.ans = '0;
    if (PARAM_REQ_I.valid) begin
      if (!PARAM_REQ_I.is_config) begin
        r_d.ans.accept = 1'b1; // RULE_13
      end else if (r_q.state == ST_OPERATION_ENABLED || r_q.state == ST_QUICK_STOP ||
                   r_q.state == ST_FAULT_REACTION) begin
        r_d.ans.reject = 1'b1; // RULE_10
      end else begin
        r_d.ans.accept = 1'b1; // RULE_10
      end
    end
    if (RAMP_STOPPED_I && r_q.state == ST_QUICK_STOP) begin
      r_d.qs_stopped = 1'b1;
    end
    // a fault outranks every command
    if (FAULT_DETECT_I && r_q.state != ST_FAULT && r_q.state != ST_FAULT_REACTION &&
        r_q.state != ST_NOT_READY) begin
      r_d.state = ST_FAULT_REACTION;
      r_d.fault_after_qs = (r_q.state == ST_QUICK_STOP);
      r_d.ramping = 1'b0;
    end else begin
      case (r_q.state) // RULE_17
        ST_NOT_READY: begin
          r_d.state = ST_SWITCH_ON_DISABLED; // RULE_16
        end
        ST_SWITCH_ON_DISABLED: begin
          if (cmd_shutdown) begin
            r_d.state = ST_READY;
          end
        end
        ST_READY: begin
          if (free_req || cmd_disable_voltage || cmd_quick_stop) begin
            r_d.state = ST_SWITCH_ON_DISABLED; // RULE_07
          end else if (cmd_enable_op) begin
            r_d.state = ST_OPERATION_ENABLED;
          end else if (cmd_switch_on) begin
            r_d.state = ST_SWITCHED_ON;
          end
        end
        ST_SWITCHED_ON: begin
          if (free_req || cmd_disable_voltage || cmd_quick_stop || cfg_write) begin
            r_d.state = ST_SWITCH_ON_DISABLED; // RULE_10
          end else if (cmd_shutdown) begin
            r_d.state = ST_READY;
          end else if (cmd_enable_op) begin
            r_d.state = ST_OPERATION_ENABLED;
          end
        end
        ST_OPERATION_ENABLED: begin
          if (free_req || cmd_disable_voltage) begin
            r_d.state = ST_SWITCH_ON_DISABLED; // RULE_07
            r_d.ramping = 1'b0;
          end else if (cmd_quick_stop) begin
            r_d.state = ST_QUICK_STOP;
            r_d.qs_stopped = 1'b0;
            r_d.ramping = 1'b0;
          end else if (cmd_shutdown) begin
            r_d.state = ST_READY;
            r_d.ramping = 1'b0;
          end else if (fast_req) begin
            r_d.state = ST_SWITCHED_ON; // RULE_06
            r_d.ramping = 1'b0;
          end else if (cmd_switch_on || r_q.ramping) begin
            // ramp down first only when the setting asks for it
            if (CFG_I.disable_stop_on_ramp && !(r_q.ramping && RAMP_STOPPED_I)) begin
              r_d.ramping = 1'b1; // RULE_15
            end else begin
              r_d.state = ST_SWITCHED_ON; // RULE_15
              r_d.ramping = 1'b0;
            end
          end
        end
        ST_QUICK_STOP: begin
          if (cmd_disable_voltage || free_req) begin
            r_d.state = ST_SWITCH_ON_DISABLED;
          end
        end
        ST_FAULT_REACTION: begin
          if (FAULT_REACTION_DONE_I) begin
            r_d.state = ST_FAULT;
          end
        end
        ST_FAULT: begin
          if (fault_reset_edge && !FAULT_CAUSE_ACTIVE_I) begin
            r_d.state = ST_SWITCH_ON_DISABLED; // RULE_03
            r_d.fault_after_qs = 1'b0;
          end
        end
        default: begin
          r_d.state = ST_NOT_READY;
        end
      endcase
    end
    // outputs follow the state just chosen, so they line up with STATE_O
    case (r_d.state) // RULE_14
      ST_SWITCH_ON_DISABLED: r_d.status = SW_SWITCH_ON_DISABLED;
      ST_READY: r_d.status = SW_READY;
      ST_SWITCHED_ON: r_d.status = SW_SWITCHED_ON;
      ST_OPERATION_ENABLED: r_d.status = SW_OPERATION_ENABLED;
      ST_QUICK_STOP: r_d.status = SW_QUICK_STOP;
      ST_FAULT_REACTION: r_d.status = SW_FAULT_REACTION;
      ST_FAULT: r_d.status = r_d.fault_after_qs ? SW_FAULT_AFTER_QS : SW_FAULT;
      default: r_d.status = SW_NOT_READY;
    endcase
    r_d.drive.reverse = pick_bit(CFG_I.fieldbus_dir_source, r_d.cmd); // RULE_09
    r_d.status[SW_VOLTAGE_ENABLED] = mains_ok;
    r_d.status[SW_DIRECTION] = r_d.drive.reverse;
    r_d.drive.halt = (r_d.state == ST_OPERATION_ENABLED) && r_d.cmd[CW_HALT]; // RULE_04
    r_d.drive.halt_stop_type = CFG_I.stop_type; // RULE_04
    r_d.drive.dc_inject = (r_d.state == ST_OPERATION_ENABLED) &&
                          pick_bit(CFG_I.fieldbus_dc_inject_source, r_d.cmd); // RULE_08
    stop_power = (r_d.state == ST_QUICK_STOP) && !r_d.qs_stopped;
    case (r_d.state)
      ST_OPERATION_ENABLED: r_d.drive.motor_power = !r_d.drive.halt; // RULE_05
      ST_QUICK_STOP: r_d.drive.motor_power = stop_power; // RULE_11
      ST_FAULT_REACTION: r_d.drive.motor_power = CFG_I.fault_motor_power; // RULE_12
      default: r_d.drive.motor_power = 1'b0; // RULE_11
    endcase
    case (r_d.state)
      ST_SWITCHED_ON, ST_OPERATION_ENABLED, ST_QUICK_STOP: r_d.drive.supply_need = 1'b1;
      ST_FAULT_REACTION: r_d.drive.supply_need = CFG_I.fault_supply_need; // RULE_12
      default: r_d.drive.supply_need = 1'b0;
    endcase
    r_d.drive.contactor = r_d.drive.supply_need;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      r_q <= '{state: ST_NOT_READY, cmd: CMD_WORD_RESET, status: SW_NOT_READY, default: '0}; // RULE_16
    end else begin
      r_q <= r_d;
    end
  end

  assign CMD_WORD_O = r_q.cmd;
  assign STATUS_WORD_O = r_q.status;
  assign STATE_O = r_q.state;
  assign PARAM_ANS_O = r_q.ans;
  assign DRIVE_O = r_q.drive;

endmodule // dcwsm_top

// [sim/dcwsm_sva.sv]
/*
  port assertions of the drive control word state machine.
  assumes one clock domain; attached to dcwsm_top by the bind at the foot.
*/
`timescale 1ns/1ns
module dcwsm_sva
  import dcwsm_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CMD_WR_I,
  input wire logic [15:0] CMD_WORD_I,
  input wire logic [15:0] CMD_WORD_O,
  input wire logic [15:0] STATUS_WORD_O,
  input wire dcwsm_pkg::dcwsm_state_t STATE_O,
  input wire dcwsm_pkg::dcwsm_cfg_t CFG_I,
  input wire logic FAULT_CAUSE_ACTIVE_I,
  input wire dcwsm_pkg::dcwsm_param_req_t PARAM_REQ_I,
  input wire dcwsm_pkg::dcwsm_param_ans_t PARAM_ANS_O,
  input wire dcwsm_pkg::dcwsm_drive_t DRIVE_O
);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  a_rsv_bits_clear: assert property (CMD_WR_I |=> CMD_WORD_O == ($past(CMD_WORD_I) & ~CMD_RESERVED_MASK))
    else $error("stored command word keeps reserved bits");
  a_status_op_code: assert property (STATE_O == ST_OPERATION_ENABLED |->
    (STATUS_WORD_O & STATUS_MASK) == SW_OPERATION_ENABLED)
    else $error("status code wrong in operation enabled");
  a_halt_no_power: assert property (DRIVE_O.halt |-> !DRIVE_O.motor_power)
    else $error("motor powered while halted");
  a_idle_no_power: assert property (STATE_O inside {ST_NOT_READY, ST_SWITCH_ON_DISABLED,
    ST_READY, ST_SWITCHED_ON, ST_FAULT} |-> !DRIVE_O.motor_power)
    else $error("motor powered in a locked state");
  a_plain_accept: assert property (PARAM_REQ_I.valid && !PARAM_REQ_I.is_config |=>
    PARAM_ANS_O.accept && !PARAM_ANS_O.reject)
    else $error("plain parameter not accepted");
  a_cfg_reject: assert property (PARAM_REQ_I.valid && PARAM_REQ_I.is_config &&
    STATE_O inside {ST_OPERATION_ENABLED, ST_QUICK_STOP} |=> PARAM_ANS_O.reject && !PARAM_ANS_O.accept)
    else $error("configuration write not rejected");
  a_cfg_forces_back: assert property (PARAM_REQ_I.valid && PARAM_REQ_I.is_config &&
    STATE_O == ST_SWITCHED_ON |=> PARAM_ANS_O.accept && STATE_O == ST_SWITCH_ON_DISABLED)
    else $error("configuration write in switched on did not return");
  a_reset_edge: assert property (STATE_O == ST_FAULT && $rose(CMD_WORD_O[CW_FAULT_RESET]) &&
    !FAULT_CAUSE_ACTIVE_I |=> STATE_O == ST_SWITCH_ON_DISABLED)
    else $error("fault reset edge not taken");
  a_fault_holds: assert property (STATE_O == ST_FAULT && !$rose(CMD_WORD_O[CW_FAULT_RESET]) |=>
    STATE_O == ST_FAULT)
    else $error("fault left without reset edge");
  // the direction output is registered together with the stored word, so both move on the same edge
  a_dir_default: assert property ($past(CFG_I.fieldbus_dir_source) == SRC_DIR_DEFAULT |->
    DRIVE_O.reverse == CMD_WORD_O[CW_ASSIGN_LSB])
    else $error("direction does not follow bit 11");
  c_halted: cover property (STATE_O == ST_OPERATION_ENABLED && DRIVE_O.halt);
  c_fault_reset: cover property (STATE_O == ST_FAULT ##1 STATE_O == ST_SWITCH_ON_DISABLED);
  c_reject: cover property (PARAM_ANS_O.reject);
endmodule // dcwsm_sva

bind dcwsm_top dcwsm_sva i_dcwsm_sva (.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .CMD_WR_I(CMD_WR_I),
  .CMD_WORD_I(CMD_WORD_I), .CMD_WORD_O(CMD_WORD_O), .STATUS_WORD_O(STATUS_WORD_O), .STATE_O(STATE_O),
  .CFG_I(CFG_I), .FAULT_CAUSE_ACTIVE_I(FAULT_CAUSE_ACTIVE_I), .PARAM_REQ_I(PARAM_REQ_I),
  .PARAM_ANS_O(PARAM_ANS_O), .DRIVE_O(DRIVE_O));

// [sim/dcwsm_plc.sv]
/*
  fieldbus master model that writes the command word.
  assumes the caller enters its tasks off the rising edge.
*/
`timescale 1ns/1ns
module dcwsm_plc (
  input wire logic clk_i,
  output logic wr_o,
  output logic [15:0] word_o
);
  initial begin
    wr_o = 1'b0;
    word_o = 16'h0000;
  end
  task automatic send(input logic [15:0] w);
    @(posedge clk_i);
    wr_o <= 1'b1;
    word_o <= w;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // data is not held once the strobe drops
    word_o <= ~w;
  endtask
  task automatic fault_reset(input logic [15:0] w);
    send(w & 16'hFF7F);
    send(w | 16'h0080);
  endtask
endmodule // dcwsm_plc

// [sim/testbench.sv]
/*
  self-checking bench of the drive control word state machine.
  assumes the plc model and the bound checker; mains pin held present.
*/
`timescale 1ns/1ns
module testbench;
  import dcwsm_pkg::*;
  logic clk, rst_n, wr, fast_pin, free_pin, fault_det, fault_cause, fault_done, ramp_done;
  logic [15:0] word, cmd_o, status;
  dcwsm_state_t state;
  dcwsm_cfg_t cfg;
  dcwsm_param_req_t preq;
  dcwsm_param_ans_t pans;
  dcwsm_drive_t drv;
  int mismatches, check_count;
  dcwsm_plc i_dcwsm_plc (.clk_i(clk), .wr_o(wr), .word_o(word));
  dcwsm_top i_dcwsm_top (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .CMD_WR_I(wr), .CMD_WORD_I(word), .CMD_WORD_O(cmd_o),
    .STATUS_WORD_O(status), .STATE_O(state), .CFG_I(cfg), .FAST_STOP_PIN_I(fast_pin), .FREEWHEEL_PIN_I(free_pin),
    .MAINS_PRESENT_PIN_I(1'b1), .FAULT_DETECT_I(fault_det), .FAULT_CAUSE_ACTIVE_I(fault_cause),
    .FAULT_REACTION_DONE_I(fault_done), .RAMP_STOPPED_I(ramp_done), .PARAM_REQ_I(preq), .PARAM_ANS_O(pans),
    .DRIVE_O(drv));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic st(input dcwsm_state_t s, input logic [15:0] sw);
    cmp("state", {13'h0000, s}, {13'h0000, state});
    cmp("status", sw, status & STATUS_MASK);
  endtask
  task automatic cw(input logic [15:0] w, input dcwsm_state_t s, input logic [15:0] sw);
    i_dcwsm_plc.send(w);
    wt(4);
    st(s, sw);
  endtask
  task automatic bit1(input string what, input logic exp, input logic got);
    cmp(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic par(input logic cfgp, input logic acc, input logic rej);
    @(posedge clk);
    preq <= '{valid: 1'b1, is_config: cfgp};
    @(posedge clk);
    preq <= '{valid: 1'b0, is_config: ~cfgp};
    @(negedge clk);
    bit1("accept", acc, pans.accept);
    bit1("reject", rej, pans.reject);
  endtask
  // ------------------------------------------------------------
  // clock, watchdog and sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    // the sequence needs well under a thousand cycles
    #100000;
    mismatches++;
    finish_test();
  end
  initial begin
    {rst_n, fast_pin, free_pin, fault_det, fault_cause, fault_done, ramp_done} = 7'h00;
    preq = '0;
    cfg = '0;
    cfg.fieldbus_dir_source = SRC_DIR_DEFAULT;
    mismatches = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wt(2);
    st(ST_SWITCH_ON_DISABLED, SW_SWITCH_ON_DISABLED);
    cw(16'h0007, ST_SWITCH_ON_DISABLED, SW_SWITCH_ON_DISABLED);
    par(1'b1, 1'b1, 1'b0);
    cw(16'h0676, ST_READY, SW_READY);
    cmp("readback", 16'h0006, cmd_o);
    bit1("voltage", 1'b1, status[SW_VOLTAGE_ENABLED]);
    cw(16'h0007, ST_SWITCHED_ON, SW_SWITCHED_ON);
    bit1("supply", 1'b1, drv.supply_need);
    bit1("contactor", 1'b1, drv.contactor);
    bit1("power", 1'b0, drv.motor_power);
    par(1'b1, 1'b1, 1'b0);
    st(ST_SWITCH_ON_DISABLED, SW_SWITCH_ON_DISABLED);
    cw(16'h0006, ST_READY, SW_READY);
    cw(16'h000F, ST_OPERATION_ENABLED, SW_OPERATION_ENABLED);
    bit1("power", 1'b1, drv.motor_power);
    par(1'b1, 1'b0, 1'b1);
    par(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      cfg.stop_type <= dcwsm_stop_t'(i);
      cw(16'h010F, ST_OPERATION_ENABLED, SW_OPERATION_ENABLED);
      cmp("halt type", i[15:0], {14'h0000, drv.halt_stop_type});
      bit1("halt power", 1'b0, drv.motor_power);
    end
    cw(16'h080F, ST_OPERATION_ENABLED, SW_OPERATION_ENABLED);
    bit1("reverse", 1'b1, drv.reverse);
    bit1("status dir", 1'b1, status[SW_DIRECTION]);
    cw(16'h0007, ST_SWITCHED_ON, SW_SWITCHED_ON);
    cw(16'h000F, ST_OPERATION_ENABLED, SW_OPERATION_ENABLED);
    @(posedge clk);
    cfg.disable_stop_on_ramp <= 1'b1;
    cw(16'h0007, ST_OPERATION_ENABLED, SW_OPERATION_ENABLED);
    @(posedge clk);
    ramp_done <= 1'b1;
    wt(2);
    st(ST_SWITCHED_ON, SW_SWITCHED_ON);
    @(posedge clk);
    ramp_done <= 1'b0;
    cfg.disable_stop_on_ramp <= 1'b0;
    cw(16'h000F, ST_OPERATION_ENABLED, SW_OPERATION_ENABLED);
    @(posedge clk);
    fast_pin <= 1'b1;
    // enable operation is still stored, so leaving state 5 is caught at its first cycle
    for (int k = 0; k < 8 && state == ST_OPERATION_ENABLED; k++) @(negedge clk);
    st(ST_SWITCHED_ON, SW_SWITCHED_ON);
    cw(16'h0007, ST_SWITCHED_ON, SW_SWITCHED_ON);
    @(posedge clk);
    fast_pin <= 1'b0;
    cw(16'h000F, ST_OPERATION_ENABLED, SW_OPERATION_ENABLED);
    @(posedge clk);
    cfg.fieldbus_dc_inject_source <= SRC_BIT15;
    cw(16'h800F, ST_OPERATION_ENABLED, SW_OPERATION_ENABLED);
    bit1("dc inject", 1'b1, drv.dc_inject);
    @(posedge clk);
    cfg.fieldbus_freewheel_source <= SRC_BIT15;
    wt(4);
    st(ST_SWITCH_ON_DISABLED, SW_SWITCH_ON_DISABLED);
    @(posedge clk);
    cfg.fieldbus_freewheel_source <= SRC_NONE;
    cw(16'h0006, ST_READY, SW_READY);
    cw(16'h000F, ST_OPERATION_ENABLED, SW_OPERATION_ENABLED);
    cw(16'h0002, ST_QUICK_STOP, SW_QUICK_STOP);
    bit1("power", 1'b1, drv.motor_power);
    // once the fast stop ramp is down, quick stop active holds the motor unpowered
    @(posedge clk);
    ramp_done <= 1'b1;
    wt(2);
    bit1("stopped power", 1'b0, drv.motor_power);
    @(posedge clk);
    {fault_det, ramp_done, cfg.fault_motor_power, cfg.fault_supply_need} <= 4'hB;
    wt(2);
    st(ST_FAULT_REACTION, SW_FAULT_REACTION);
    bit1("power", 1'b1, drv.motor_power);
    bit1("supply", 1'b1, drv.supply_need);
    @(posedge clk);
    {fault_det, fault_done, fault_cause} <= 3'h3;
    wt(2);
    st(ST_FAULT, SW_FAULT_AFTER_QS);
    bit1("fault power", 1'b0, drv.motor_power);
    i_dcwsm_plc.fault_reset(16'h0000);
    wt(4);
    st(ST_FAULT, SW_FAULT_AFTER_QS);
    @(posedge clk);
    {fault_done, fault_cause} <= 2'h0;
    cw(16'h0080, ST_FAULT, SW_FAULT_AFTER_QS);
    i_dcwsm_plc.fault_reset(16'h0000);
    wt(4);
    st(ST_SWITCH_ON_DISABLED, SW_SWITCH_ON_DISABLED);
    @(posedge clk);
    rst_n <= 1'b0;
    wt(2);
    st(ST_NOT_READY, SW_NOT_READY);
    @(posedge clk);
    rst_n <= 1'b1;
    wt(2);
    st(ST_SWITCH_ON_DISABLED, SW_SWITCH_ON_DISABLED);
    finish_test();
  end
endmodule // testbench
